// ---- logic/ana_regs.sv ----
// auto-negotiation advertisement, partner ability and expansion registers
// assumes page and fault events come from a negotiation engine on clk_i
`timescale 1ns/1ps

// Function
// - advert write stored now, applied on trigger
// - advert bits 6,5 read-write, default one
// - partner bit 15 is received next page
// - partner bit 14 is received acknowledge
// - partner bit 13 is received remote fault
// - partner bits 11,10 are received pause abilities
// - partner bits 9..5 are received technologies
// - partner register read-only, mirrors code word, zero
// - partner bits 4..0 are received selector
// - parallel detection fault latched, clear on read
// - partner next page ability latched high
// - local next page ability reads one
// - page received latched, clear on read
// - partner auto-negotiation ability bit
module ana_regs
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // classic wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   // negotiation engine side
   input  wire logic        page_rx_i,
   input  wire logic [15:0] page_word_i,
   input  wire logic        pd_fault_i,
   input  wire logic        partner_an_able_i,
   input  wire logic        link_up_i,
   // advertisement actually in effect
   output logic      [15:0] adv_applied_o,
   output logic             soft_reset_o,
   output logic             restart_an_o,
   output logic             power_down_o,
   output logic             irq_o
);

   typedef struct packed {
      logic [15:0]             adv;
      logic [15:0]             applied;
      logic [15:0]             partner;
      logic                    pdf;
      logic                    lpnp;
      logic                    pgrx;
      logic                    pwrdn;
      logic                    swrst;
      logic                    restart;
      logic                    link_q;
      logic [ana_pkg::ANA_IRQ_W-1:0] istat;
      logic [ana_pkg::ANA_IRQ_W-1:0] imask;
      logic                    irq;
      logic                    ack;
      logic                    err;
      logic [31:0]             rdat;
   } ana_state_s;

   ana_state_s st_reg;
   ana_state_s st_next;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // byte-lane merge of a 16-bit register under wishbone select
   function automatic logic [15:0] ana_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  sel);
      logic [15:0] res;
      res = old_v;
      if (sel[0])
      begin
         res[7:0] = new_v[7:0];
      end
      if (sel[1])
      begin
         res[15:8] = new_v[15:8];
      end
      return res;
   endfunction : ana_merge

   // expansion register image
   function automatic logic [15:0] ana_expand(input ana_state_s s,
                                              input logic       an_able);
      logic [15:0] v;
      v = 16'h0000;
      v[ana_pkg::ANA_EXP_PDF]  = s.pdf;
      v[ana_pkg::ANA_EXP_LPNP] = s.lpnp;
      v[ana_pkg::ANA_EXP_LNP]  = 1'b1;
      v[ana_pkg::ANA_EXP_PGRX] = s.pgrx;
      v[ana_pkg::ANA_EXP_LPAN] = an_able;
      return v;
   endfunction : ana_expand

   ////////////////////////////////////////////////////////////////////////
   // next state

   logic        req;
   logic        wr;
   logic        rd;
   logic [3:0]  idx;
   logic        apply;
   logic        link_lost;
   logic        rd_exp;
   logic [15:0] wdat;
   logic [ana_pkg::ANA_IRQ_W-1:0] iev;

   always_comb
   begin
      st_next   = st_reg;
      // one-cycle ack; the ack cycle itself never starts a second request
      req       = wb_cyc_i && wb_stb_i && !st_reg.ack && !st_reg.err;
      wr        = req && wb_we_i;
      rd        = req && !wb_we_i;
      idx       = wb_adr_i[5:2];
      wdat      = wb_dat_i[15:0];
      rd_exp    = rd && (idx == ana_pkg::ANA_IDX_EXPAND);
      link_lost = st_reg.link_q && !link_up_i;
      st_next.link_q  = link_up_i;
      st_next.ack     = 1'b0;
      st_next.err     = 1'b0;
      st_next.swrst   = 1'b0;
      st_next.restart = 1'b0;
      st_next.rdat    = 32'h0000_0000;

      // register write decode
      if (wr && idx == ana_pkg::ANA_IDX_ADVERT)
      begin
         st_next.adv = ana_merge(st_reg.adv, wdat, wb_sel_i[1:0]);
      end
      else if (wr && idx == ana_pkg::ANA_IDX_CTRL)
      begin
         if (wb_sel_i[1])
         begin
            st_next.swrst   = wdat[ana_pkg::ANA_CTRL_SWRST];
            st_next.restart = wdat[ana_pkg::ANA_CTRL_RESTART];
            st_next.pwrdn   = wdat[ana_pkg::ANA_CTRL_PWRDN];
         end
      end
      else if (wr && idx == ana_pkg::ANA_IDX_IRQ_MASK)
      begin
         if (wb_sel_i[0])
         begin
            st_next.imask = wdat[ana_pkg::ANA_IRQ_W-1:0];
         end
      end

      // write-one-to-clear status; events below still win
      if (wr && idx == ana_pkg::ANA_IDX_IRQ_STAT && wb_sel_i[0])
      begin
         st_next.istat = st_reg.istat & ~wdat[ana_pkg::ANA_IRQ_W-1:0];
      end

      // read mux, expansion uses the pre-clear image
      if (rd && idx == ana_pkg::ANA_IDX_ADVERT)
      begin
         st_next.rdat = {16'h0000, st_reg.adv};
      end
      else if (rd && idx == ana_pkg::ANA_IDX_PARTNER)
      begin
         st_next.rdat = {16'h0000, st_reg.partner};
      end
      else if (rd && idx == ana_pkg::ANA_IDX_EXPAND)
      begin
         st_next.rdat = {16'h0000, ana_expand(st_reg, partner_an_able_i)};
      end
      else if (rd && idx == ana_pkg::ANA_IDX_CTRL)
      begin
         st_next.rdat = 32'h0000_0000;
         st_next.rdat[ana_pkg::ANA_CTRL_PWRDN] = st_reg.pwrdn;
      end
      else if (rd && idx == ana_pkg::ANA_IDX_IRQ_STAT)
      begin
         st_next.rdat = {29'h0000_0000, st_reg.istat};
      end
      else if (rd && idx == ana_pkg::ANA_IDX_IRQ_MASK)
      begin
         st_next.rdat = {29'h0000_0000, st_reg.imask};
      end
      else if (rd && idx == ana_pkg::ANA_IDX_APPLIED)
      begin
         st_next.rdat = {16'h0000, st_reg.applied};
      end

      // unmapped address answers with err instead of ack
      if (req)
      begin
         if (idx == ana_pkg::ANA_IDX_ADVERT   || idx == ana_pkg::ANA_IDX_PARTNER  ||
             idx == ana_pkg::ANA_IDX_EXPAND   || idx == ana_pkg::ANA_IDX_CTRL     ||
             idx == ana_pkg::ANA_IDX_IRQ_STAT || idx == ana_pkg::ANA_IDX_IRQ_MASK ||
             idx == ana_pkg::ANA_IDX_APPLIED)
         begin
            st_next.ack = 1'b1;
         end
         else
         begin
            st_next.err = 1'b1;
         end
      end

      // read of expansion clears the pdf and pgrx latches, lpnp stays; a same-cycle event wins
      if (rd_exp)
      begin
         st_next.pdf  = 1'b0;
         st_next.pgrx = 1'b0;
      end

      // received base page fills partner register
      if (page_rx_i)
      begin
         st_next.partner = page_word_i;
         st_next.pgrx    = 1'b1;
         if (page_word_i[ana_pkg::ANA_CW_NP])
         begin
            st_next.lpnp = 1'b1;
         end
      end
      if (pd_fault_i)
      begin
         st_next.pdf = 1'b1;
      end

      // staged advertisement goes live on any of the four triggers
      apply = st_next.swrst || st_next.restart || link_lost ||
              (st_reg.pwrdn && !st_next.pwrdn);
      if (apply)
      begin
         st_next.applied = st_reg.adv;
         if (wr && idx == ana_pkg::ANA_IDX_ADVERT)
         begin
            st_next.applied = st_next.adv;
         end
      end

      // software reset clears the soft-cleared fields
      if (st_next.swrst)
      begin
         st_next.partner = 16'h0000;
         st_next.pdf     = 1'b0;
         st_next.lpnp    = 1'b0;
      end

      // sticky interrupt events, set beats clear
      iev = '0;
      iev[ana_pkg::ANA_IRQ_PAGE]   = page_rx_i;
      iev[ana_pkg::ANA_IRQ_PDF]    = pd_fault_i;
      iev[ana_pkg::ANA_IRQ_LINKDN] = link_lost;
      st_next.istat = st_next.istat | iev;
      st_next.irq   = |(st_next.istat & st_next.imask);
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_reg         <= '0;
         st_reg.adv     <= ana_pkg::ANA_ADV_RESET;
         st_reg.applied <= ana_pkg::ANA_ADV_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register

   assign wb_dat_o      = st_reg.rdat;
   assign wb_ack_o      = st_reg.ack;
   assign wb_err_o      = st_reg.err;
   assign adv_applied_o = st_reg.applied;
   assign soft_reset_o  = st_reg.swrst;
   assign restart_an_o  = st_reg.restart;
   assign power_down_o  = st_reg.pwrdn;
   assign irq_o         = st_reg.irq;

endmodule : ana_regs

// ---- common/ana_pkg.sv ----
// package for the auto-negotiation ability register bank
// assumes a 32-bit classic wishbone slave, one register per aligned word
package ana_pkg;

   // printed register indices; byte address is four times the index
   localparam logic [3:0]  ANA_IDX_ADVERT   = 4'h4;
   localparam logic [3:0]  ANA_IDX_PARTNER  = 4'h5;
   localparam logic [3:0]  ANA_IDX_EXPAND   = 4'h6;
   localparam logic [3:0]  ANA_IDX_CTRL     = 4'h8;
   localparam logic [3:0]  ANA_IDX_IRQ_STAT = 4'h9;
   localparam logic [3:0]  ANA_IDX_IRQ_MASK = 4'ha;
   localparam logic [3:0]  ANA_IDX_APPLIED  = 4'hb;

   // advertisement field layout and reset value
   localparam int          ANA_ADV_FD10     = 6;
   localparam int          ANA_ADV_HD10     = 5;
   localparam logic [15:0] ANA_ADV_RESET    = 16'h01e1;

   // control register bits
   localparam int          ANA_CTRL_SWRST   = 15;
   localparam int          ANA_CTRL_PWRDN   = 11;
   localparam int          ANA_CTRL_RESTART = 9;

   // expansion register bits
   localparam int          ANA_EXP_PDF      = 4;
   localparam int          ANA_EXP_LPNP     = 3;
   localparam int          ANA_EXP_LNP      = 2;
   localparam int          ANA_EXP_PGRX     = 1;
   localparam int          ANA_EXP_LPAN     = 0;

   // partner base word bit that flags next page ability
   localparam int          ANA_CW_NP        = 15;

   // interrupt status layout
   localparam int          ANA_IRQ_PAGE     = 0;
   localparam int          ANA_IRQ_PDF      = 1;
   localparam int          ANA_IRQ_LINKDN   = 2;
   localparam int          ANA_IRQ_W        = 3;

endpackage : ana_pkg

// ---- testbench/ana_regs_asserts.sv ----
// checker for the negotiation ability register bank
// assumes it sees only the top ports; bound after the module
`timescale 1ns/1ps
module ana_regs_asserts
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [5:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        wb_err_o,
   input wire logic        page_rx_i,
   input wire logic [15:0] page_word_i,
   input wire logic        partner_an_able_i,
   input wire logic        link_up_i,
   input wire logic [15:0] adv_applied_o,
   input wire logic        soft_reset_o,
   input wire logic        restart_an_o,
   input wire logic        power_down_o
);
   logic        take, cw, lnk_q, ldn_q, rdp_q, rdx_q, an_q, sr_q, rs_q;
   logic [15:0] lw_q;
   assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign cw   = take & wb_we_i & wb_sel_i[1] & (wb_adr_i == 6'h20);
   // shadow of the received word, cleared with the soft reset write
   always_ff @(posedge clk_i)
   begin
      lnk_q <= link_up_i;
      ldn_q <= lnk_q & ~link_up_i;
      rdp_q <= take & ~wb_we_i & (wb_adr_i == 6'h14);
      rdx_q <= take & ~wb_we_i & (wb_adr_i == 6'h18);
      an_q  <= partner_an_able_i;
      sr_q  <= cw & wb_dat_i[15];
      rs_q  <= cw & wb_dat_i[9];
      if (rst_i || (cw && wb_dat_i[15]))
         lw_q <= 16'h0000;
      else if (page_rx_i)
         lw_q <= page_word_i;
   end
   ////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_one_answer: assert property (take |=> wb_ack_o ^ wb_err_o)
      else $error("request not answered once");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_err_unmapped: assert property (take && !(wb_adr_i[5:2] inside
      {4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb}) |=> wb_err_o && !wb_ack_o)
      else $error("unmapped access not refused");
   a_partner_mirror: assert property (rdp_q && wb_ack_o |-> wb_dat_o[15:0] == lw_q)
      else $error("partner word mismatch");
   a_expand_fixed: assert property (rdx_q && wb_ack_o |-> wb_dat_o[15:5] == 11'h000
      && wb_dat_o[2] && wb_dat_o[0] == an_q)
      else $error("expansion fixed bits wrong");
   a_soft_pulse: assert property (sr_q |-> soft_reset_o ##1 !soft_reset_o)
      else $error("soft reset pulse wrong");
   a_restart_cause: assert property (restart_an_o |-> rs_q)
      else $error("restart pulse without write");
   a_restart_pulse: assert property (rs_q |-> restart_an_o ##1 !restart_an_o)
      else $error("restart pulse missing");
   a_applied_hold: assert property (!$stable(adv_applied_o) |-> soft_reset_o
      || restart_an_o || $fell(power_down_o) || ldn_q)
      else $error("advert applied without trigger");
   c_partner_read: cover property (rdp_q && wb_ack_o);
   c_link_drop: cover property (ldn_q);
   c_soft_reset: cover property (sr_q);
   c_restart: cover property (rs_q);
endmodule : ana_regs_asserts

bind ana_regs ana_regs_asserts ana_regs_asserts_i
(
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .wb_err_o, .page_rx_i, .page_word_i, .partner_an_able_i,
   .link_up_i, .adv_applied_o, .soft_reset_o, .restart_an_o, .power_down_o
);

// ---- testbench/ana_host.sv ----
// station host model: classic wishbone master, one cycle at a time
// assumes a slave answering with a one-cycle ack or err
`timescale 1ns/1ps
module ana_host
(
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic        err_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic      [5:0]  adr_o,
   output logic      [3:0]  sel_o,
   output logic      [31:0] dat_o
);
   initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   // request held until answered, then idle one cycle
   task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
                       output logic [15:0] rd, output logic e);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h3, 16'h0000, d};
      do @(posedge clk_i); while (!(ack_i | err_i));
      rd = dat_i[15:0];
      e  = err_i;
      {cyc_o, stb_o, we_o} <= 3'b000;
      @(posedge clk_i);
   endtask : xfer
endmodule : ana_host

// ---- testbench/test_ana_regs.sv ----
// self-checking bench for the negotiation ability register bank
// assumes the host model drives the register bus
`timescale 1ns/1ps
module test_ana_regs;
   logic        clk_i = 0, rst_i = 1, page_rx_i = 0, pd_fault_i = 0;
   logic        partner_an_able_i = 0, link_up_i = 1, e, irq_o;
   logic        soft_reset_o, restart_an_o, power_down_o;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
   logic [5:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] page_word_i = '0, rd, w, adv, adv_applied_o;
   int          fails = 0, compares = 0;
   initial forever #2.5 clk_i = ~clk_i;
   ana_host ana_host_i
   (
      .clk_i, .ack_i(wb_ack_o), .err_i(wb_err_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
      .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i)
   );
   ana_regs ana_regs_i
   (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .wb_err_o, .page_rx_i, .page_word_i, .pd_fault_i,
      .partner_an_able_i, .link_up_i, .adv_applied_o, .soft_reset_o, .restart_an_o,
      .power_down_o, .irq_o
   );
   ////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
      compares++;
      if (g !== x)
      begin
         $display("unexpected %s expected %h seen %h", n, x, g);
         fails++;
      end
   endtask : chk
   task automatic acc(input logic wr, input logic [5:0] a, input logic [15:0] d);
      ana_host_i.xfer(wr, a, d, rd, e);
   endtask : acc
   task automatic rdc(input string n, input logic [5:0] a, input logic [15:0] x);
      acc(1'b0, a, 16'h0000);
      chk(n, x, rd);
   endtask : rdc
   // one-cycle event: 0 page, 1 fault, 2 link drop
   task automatic ev(input int k, input logic [15:0] v);
      @(posedge clk_i);
      page_word_i <= v;
      page_rx_i   <= (k == 0);
      pd_fault_i  <= (k == 1);
      link_up_i   <= (k != 2);
      @(posedge clk_i);
      {page_rx_i, pd_fault_i, link_up_i} <= 3'b001;
      @(posedge clk_i);
   endtask : ev
   function automatic logic [15:0] xp(logic f, logic n, logic p, logic a);
      return {11'h000, f, n, 1'b1, p, a};
   endfunction : xp
   task automatic close_out();
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////
   initial
   begin
      repeat (4000) @(posedge clk_i);
      fails++;
      close_out();
   end
   initial
   begin
      void'($urandom(64333));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc("advert", 6'h10, 16'h01e1);
      rdc("partner", 6'h14, 16'h0000);
      rdc("expand", 6'h18, xp(0, 0, 0, 0));
      adv = 16'h01e1;
      // each trigger kind in turn; entering power down must not apply
      for (int t = 0; t < 4; t++)
      begin
         w = {9'h003, 2'(t), 5'h01};
         acc(1'b1, 6'h10, w);
         if (t == 2)
         begin
            acc(1'b1, 6'h20, 16'h0800);
            chk("power_down", 16'h0001, {15'h0000, power_down_o});
            rdc("ctrl", 6'h20, 16'h0800);
         end
         rdc("advert", 6'h10, w);
         chk("applied", adv, adv_applied_o);
         case (t)
            0: acc(1'b1, 6'h20, 16'h8000);
            1: acc(1'b1, 6'h20, 16'h0200);
            2: acc(1'b1, 6'h20, 16'h0000);
            default: ev(2, w);
         endcase
         adv = w;
         chk("applied", adv, adv_applied_o);
         chk("power_down", 16'h0000, {15'h0000, power_down_o});
         chk("pulses", 16'h0000, {14'h0000, soft_reset_o, restart_an_o});
      end
      for (int k = 0; k < 4; k++)
      begin
         w = 16'($urandom());
         w[15] = k[1];
         partner_an_able_i <= 1'($urandom());
         ev(0, w);
         rdc("partner", 6'h14, w);
         rdc("expand", 6'h18, xp(0, k[1], 1, partner_an_able_i));
         rdc("expand", 6'h18, xp(0, k[1], 0, partner_an_able_i));
      end
      acc(1'b1, 6'h14, 16'hffff);
      rdc("partner", 6'h14, w);
      acc(1'b1, 6'h18, 16'hffff);
      rdc("expand", 6'h18, xp(0, 1, 0, partner_an_able_i));
      acc(1'b0, 6'h3c, 16'h0000);
      chk("error", 16'h0001, {15'h0000, e});
      acc(1'b1, 6'h28, 16'h0002);
      ev(1, w);
      @(negedge clk_i);
      chk("irq", 16'h0001, {15'h0000, irq_o});
      rdc("expand", 6'h18, xp(1, 1, 0, partner_an_able_i));
      rdc("expand", 6'h18, xp(0, 1, 0, partner_an_able_i));
      acc(1'b1, 6'h24, 16'h0002);
      @(negedge clk_i);
      chk("irq", 16'h0000, {15'h0000, irq_o});
      acc(1'b1, 6'h28, 16'h0000);
      ev(1, w);
      @(negedge clk_i);
      chk("irq", 16'h0000, {15'h0000, irq_o});
      acc(1'b1, 6'h20, 16'h8000);
      rdc("partner", 6'h14, 16'h0000);
      rdc("expand", 6'h18, xp(0, 0, 0, partner_an_able_i));
      close_out();
   end
endmodule : test_ana_regs
